// File: cig_unit.sv
/*
 * Interrupt acceptance, entry, return and core registers of the 8-bit core:
 * flag register, stack pointer pair and configuration change guard.
 * Assumes the sequencer pulses instrDone at each instruction end, with the
 * instr* strobes describing that instruction, and returns stack read data
 * one cycle after stackRd.
 */
// Contract
// - Request taken only when its own enable and the global enable are set.
// - Lower vector wins; reset first, external request zero next.
// - Accepting an interrupt clears the global enable.
// - Return instruction sets the global enable; software may set it earlier.
// - Vectoring clears the flag of the serviced flag-type source.
// - Writing one clears a flag; writing zero leaves it.
// - Flags raised while disabled are held and serviced later by priority.
// - Level requests act only while present; vanished ones are lost.
// - After return one main instruction runs before any new request.
// - Global disable acts at once, even against a simultaneous request.
// - After global enable the following instruction runs before any request.
// - Entry takes four cycles pushing the PC, after the current instruction.
// - Wake from sleep adds four cycles to entry.
// - Return takes four cycles: pop PC, stack pointer plus two, enable set.
// - Signature D8 unlocks protected registers four instructions; interrupts wait.
// - Guard bit 0 reads one while unlocked; bits 7 to 2 read zero.
// - Signature E7 sets guard bit 1 for four instructions, then clears.
// - Guard bits 0 and 1 readable; other bits write-only, read zero.
// - Stack pointer is high byte and low byte, resets to last SRAM address.
// - Flag register at data address 5F, I/O address 3F.
// - Sign flag always equals negative xor overflow.
`timescale 1ns/1ns
`default_nettype none
module cig_unit #(
   parameter int N = 8,
   parameter logic [N-1:0] LEVEL_MASK = '0,
   parameter int PC_W = 9
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic [7:0] busAddr,
   input wire logic busIoSpace,
   input wire logic busWrite,
   input wire logic busRead,
   input wire logic [7:0] busWdata,
   output logic [7:0] busRdata,
   input wire logic instrDone,
   input wire logic instrSei,
   input wire logic instrDis,
   input wire logic instrExit,
   input wire logic sleeping,
   input wire logic aluWe,
   input wire logic [7:0] aluFlags,
   input wire logic [PC_W-1:0] pcIn,
   input wire logic [N-1:0] srcCond,
   input wire logic [N-1:0] srcEnable,
   input wire logic [N-1:0] swClear,
   input wire logic [7:0] stackRdData,
   output logic [7:0] flagsOut,
   output logic [15:0] stackPtr,
   output logic [15:0] stackAddr,
   output logic stackWe,
   output logic stackRd,
   output logic [7:0] stackWdata,
   output logic coreHold,
   output logic vectorValid,
   output logic [$clog2(N)-1:0] vectorIdx,
   output logic returnValid,
   output logic [PC_W-1:0] returnPc,
   output logic unlockIo,
   output logic unlockProg
);
   cig_link_if #(.N(N)) link ();
   cig_pkg::cig_state_e state;
   logic [2:0] cnt;
   logic [7:0] addr;
   logic wrFlags;
   logic wrSpLo;
   logic wrSpHi;
   logic accept;
   logic retStart;
   logic [7:0] popHigh;
   logic [15:0] pcWide;
   logic [7:0] next_flags;

   // Elaboration check of the PC width
   if (PC_W < 1 || PC_W > 16) begin : g_bad_pc
      $error("cig_unit: PC_W must be 1..16");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Submodules
   cig_track #(.N(N), .LEVEL_MASK(LEVEL_MASK)) u_track (
      .clock(clock),
      .srst(srst),
      .srcCond(srcCond),
      .srcEnable(srcEnable),
      .swClear(swClear),
      .link(link.track)
   );

   cig_guard u_guard (
      .clock(clock),
      .srst(srst),
      .link(link.guard)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Address decode; I/O instructions address 0x20 lower
   assign addr = busIoSpace ? 8'(busAddr + cig_pkg::IO_OFFSET) : busAddr;
   assign wrFlags = busWrite && addr == cig_pkg::ADDR_FLAGS;
   assign wrSpLo = busWrite && addr == cig_pkg::ADDR_SP_LOW;
   assign wrSpHi = busWrite && addr == cig_pkg::ADDR_SP_HIGH;
   assign link.guardWrite = busWrite && addr == cig_pkg::ADDR_GUARD;
   assign link.guardData = busWdata;
   assign link.instrDone = instrDone;
   assign unlockIo = link.unlockIo;
   assign unlockProg = link.unlockProg;
   assign pcWide = 16'(pcIn);

   // Acceptance only at an instruction end (or from sleep)
   assign accept = state == cig_pkg::ST_RUN && (instrDone || sleeping)
      && link.pendAny
      && flagsOut[cig_pkg::GIE_BIT]
      && !instrDis
      && !instrSei
      && !instrExit
      && !link.unlockIo && !link.unlockProg;
   assign retStart = state == cig_pkg::ST_RUN && instrDone && instrExit;

   // Serviced flag is cleared when the vector is taken
   assign link.hwClear = accept ? (N'(1) << link.pendIdx) : '0;

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer: run, wake, entry, return
   always_ff @(posedge clock) begin
      if (srst) begin
         state <= cig_pkg::ST_RUN;
         cnt <= 3'h0;
      end else begin
         case (state)
            cig_pkg::ST_RUN: begin
               cnt <= 3'h0;
               if (accept) begin
                  state <= sleeping ? cig_pkg::ST_WAKE : cig_pkg::ST_ENTRY;
               end else if (retStart) begin
                  state <= cig_pkg::ST_RETURN;
               end
            end
            cig_pkg::ST_WAKE: begin
               cnt <= cnt + 3'h1;
               if (cnt == cig_pkg::WAKE_CYCLES - 3'h1) begin
                  cnt <= 3'h0;
                  state <= cig_pkg::ST_ENTRY;
               end
            end
            cig_pkg::ST_ENTRY: begin
               cnt <= cnt + 3'h1;
               if (cnt == cig_pkg::ENTRY_CYCLES - 3'h1) begin
                  state <= cig_pkg::ST_RUN;
               end
            end
            cig_pkg::ST_RETURN: begin
               cnt <= cnt + 3'h1;
               if (cnt == cig_pkg::RETURN_CYCLES - 3'h1) begin
                  state <= cig_pkg::ST_RUN;
               end
            end
            default: begin
               state <= cig_pkg::ST_RUN;
               cnt <= 3'h0;
            end
         endcase
      end
   end

   // Core hold while entering or returning
   always_ff @(posedge clock) begin
      if (srst) begin
         coreHold <= 1'b0;
      end else begin
         coreHold <= accept || retStart
            || (state != cig_pkg::ST_RUN && !(cnt == 3'h3 && state != cig_pkg::ST_WAKE));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Vector hand-off at the end of entry
   always_ff @(posedge clock) begin
      if (srst) begin
         vectorValid <= 1'b0;
         vectorIdx <= '0;
      end else begin
         vectorValid <= state == cig_pkg::ST_ENTRY && cnt == cig_pkg::ENTRY_CYCLES - 3'h1;
         if (accept) begin
            vectorIdx <= link.pendIdx;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Stack traffic: push PC low then high, pop high then low
   always_ff @(posedge clock) begin
      if (srst) begin
         stackWe <= 1'b0;
         stackRd <= 1'b0;
         stackAddr <= 16'h0000;
         stackWdata <= 8'h00;
      end else begin
         stackWe <= 1'b0;
         stackRd <= 1'b0;
         if (state == cig_pkg::ST_ENTRY && cnt == 3'h0) begin
            stackWe <= 1'b1;
            stackAddr <= stackPtr;
            stackWdata <= pcWide[7:0];
         end else if (state == cig_pkg::ST_ENTRY && cnt == 3'h1) begin
            stackWe <= 1'b1;
            stackAddr <= stackPtr;
            stackWdata <= pcWide[15:8];
         end else if (state == cig_pkg::ST_RETURN && cnt == 3'h0) begin
            stackRd <= 1'b1;
            stackAddr <= stackPtr + 16'h0001;
         end else if (state == cig_pkg::ST_RETURN && cnt == 3'h1) begin
            stackRd <= 1'b1;
            stackAddr <= stackPtr + 16'h0002;
         end
      end
   end

   // Popped bytes and return address; read data lags stackRd by a cycle
   always_ff @(posedge clock) begin
      if (srst) begin
         popHigh <= 8'h00;
         returnPc <= '0;
         returnValid <= 1'b0;
      end else begin
         returnValid <= 1'b0;
         if (state == cig_pkg::ST_RETURN && cnt == 3'h2) begin
            popHigh <= stackRdData;
         end
         if (state == cig_pkg::ST_RETURN && cnt == cig_pkg::RETURN_CYCLES - 3'h1) begin
            returnPc <= PC_W'({popHigh, stackRdData});
            returnValid <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Stack pointer byte pair
   always_ff @(posedge clock) begin
      if (srst) begin
         stackPtr <= cig_pkg::LAST_SRAM_ADDRESS;
      end else if (state == cig_pkg::ST_ENTRY && cnt <= 3'h1) begin
         stackPtr <= stackPtr - 16'h0001;
      end else if (state == cig_pkg::ST_RETURN && cnt == cig_pkg::RETURN_CYCLES - 3'h1) begin
         stackPtr <= stackPtr + 16'h0002;
      end else begin
         if (wrSpHi) begin
            stackPtr[15:8] <= busWdata;
         end
         if (wrSpLo) begin
            stackPtr[7:0] <= busWdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Flag register next value
   always_comb begin
      next_flags = flagsOut;
      if (aluWe) begin
         next_flags[6:0] = aluFlags[6:0];
      end
      if (wrFlags) begin
         next_flags = busWdata;
      end
      if (instrSei && instrDone) begin
         next_flags[cig_pkg::GIE_BIT] = 1'b1;
      end
      if (instrDis && instrDone) begin
         next_flags[cig_pkg::GIE_BIT] = 1'b0;
      end
      if (accept) begin
         next_flags[cig_pkg::GIE_BIT] = 1'b0;
      end
      if (state == cig_pkg::ST_RETURN && cnt == cig_pkg::RETURN_CYCLES - 3'h1) begin
         next_flags[cig_pkg::GIE_BIT] = 1'b1;
      end
      next_flags[cig_pkg::SIGN_BIT] = next_flags[cig_pkg::NEG_BIT] ^ next_flags[cig_pkg::OVF_BIT];
   end

   // Not saved on entry nor restored on return; software owns that
   always_ff @(posedge clock) begin
      if (srst) begin
         flagsOut <= cig_pkg::FLAGS_RESET;
      end else begin
         flagsOut <= next_flags;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register read-back, one cycle after busRead
   always_ff @(posedge clock) begin
      if (srst) begin
         busRdata <= 8'h00;
      end else if (busRead) begin
         case (addr)
            cig_pkg::ADDR_GUARD: busRdata <= {6'h00, link.unlockProg, link.unlockIo};
            cig_pkg::ADDR_SP_LOW: busRdata <= stackPtr[7:0];
            cig_pkg::ADDR_SP_HIGH: busRdata <= stackPtr[15:8];
            cig_pkg::ADDR_FLAGS: busRdata <= flagsOut;
            default: busRdata <= 8'h00;
         endcase
      end
   end
endmodule
`default_nettype wire

// File: cig_pkg.sv
/*
 * Constants, register map and state encoding of the interrupt and guard unit.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cig_pkg;
   // Data-space register addresses
   localparam logic [7:0] ADDR_GUARD = 8'h3C;
   localparam logic [7:0] ADDR_SP_LOW = 8'h3D;
   localparam logic [7:0] ADDR_SP_HIGH = 8'h3E;
   localparam logic [7:0] ADDR_FLAGS = 8'h5F;
   localparam logic [7:0] IO_OFFSET = 8'h20;
   // Guard signatures and read-back bits
   localparam logic [7:0] SIG_PROT_UNLOCK = 8'hD8;
   localparam logic [7:0] SIG_SELF_PROG = 8'hE7;
   localparam int GUARD_IO_BIT = 0;
   localparam int GUARD_SP_BIT = 1;
   localparam logic [2:0] GUARD_INSTR = 3'h4;
   localparam logic [7:0] GUARD_RESET = 8'h00;
   // Flag register layout and reset
   localparam int GIE_BIT = 7;
   localparam int SIGN_BIT = 4;
   localparam int OVF_BIT = 3;
   localparam int NEG_BIT = 2;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   // Cycle counts
   localparam logic [2:0] ENTRY_CYCLES = 3'h4;
   localparam logic [2:0] WAKE_CYCLES = 3'h4;
   localparam logic [2:0] RETURN_CYCLES = 3'h4;
   // Stack pointer reset, the last SRAM byte
   localparam logic [15:0] LAST_SRAM_ADDRESS = 16'h005F;
   // Sequencer states
   typedef enum logic [3:0] {
      ST_RUN = 4'h1,
      ST_WAKE = 4'h2,
      ST_ENTRY = 4'h4,
      ST_RETURN = 4'h8
   } cig_state_e;
endpackage

// File: cig_link_if.sv
/*
 * Carrier between the top unit, the request tracker and the guard.
 * Assumes all users run on the one CPU clock.
 */
`timescale 1ns/1ns
`default_nettype none
interface cig_link_if #(parameter int N = 8);
   logic [N-1:0] pending;
   logic [N-1:0] flags;
   logic [N-1:0] hwClear;
   logic pendAny;
   logic [$clog2(N)-1:0] pendIdx;
   logic guardWrite;
   logic [7:0] guardData;
   logic instrDone;
   logic unlockIo;
   logic unlockProg;
   modport track (input hwClear, output pending, flags, pendAny, pendIdx);
   modport guard (input guardWrite, guardData, instrDone, output unlockIo, unlockProg);
   modport core (output hwClear, guardWrite, guardData, instrDone,
                 input pending, flags, pendAny, pendIdx, unlockIo, unlockProg);
endinterface
`default_nettype wire

// File: cig_guard.sv
/*
 * Configuration change guard: signature detection and timed unlock windows.
 * Assumes instrDone pulses once per completed instruction.
 */
`timescale 1ns/1ns
`default_nettype none
module cig_guard (
   input wire logic clock,
   input wire logic srst,
   cig_link_if.guard link
);
   logic [2:0] left;

   ////////////////////////////////////////////////////////////////////////////
   // Window counter, counted in instructions
   always_ff @(posedge clock) begin
      if (srst) begin
         left <= 3'h0;
         link.unlockIo <= 1'b0;
         link.unlockProg <= 1'b0;
      end else if (link.guardWrite && link.guardData == cig_pkg::SIG_PROT_UNLOCK) begin
         left <= cig_pkg::GUARD_INSTR;
         link.unlockIo <= 1'b1;
         link.unlockProg <= 1'b0;
      end else if (link.guardWrite && link.guardData == cig_pkg::SIG_SELF_PROG) begin
         left <= cig_pkg::GUARD_INSTR;
         link.unlockIo <= 1'b0;
         link.unlockProg <= 1'b1;
      end else if (link.instrDone && left != 3'h0) begin
         left <= left - 3'h1;
         if (left == 3'h1) begin
            link.unlockIo <= 1'b0;
            link.unlockProg <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// File: cig_track.sv
/*
 * Request tracker: latched flags, level requests, enables and fixed priority.
 * Assumes source conditions are already synchronous to the CPU clock.
 */
`timescale 1ns/1ns
`default_nettype none
module cig_track #(
   parameter int N = 8,
   parameter logic [N-1:0] LEVEL_MASK = '0
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic [N-1:0] srcCond,
   input wire logic [N-1:0] srcEnable,
   input wire logic [N-1:0] swClear,
   cig_link_if.track link
);
   logic [N-1:0] flags;
   logic [N-1:0] req;

   // Elaboration check of the source count
   if (N < 2 || N > 32) begin : g_bad_n
      $error("cig_track: N must be 2..32");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky flags; a new event wins over either clear
   always_ff @(posedge clock) begin
      if (srst) begin
         flags <= '0;
      end else begin
         flags <= ((flags & ~(link.hwClear | swClear)) | srcCond) & ~LEVEL_MASK;
      end
   end

   // Flag sources use the flag, level sources the live condition
   assign req = ((flags & ~LEVEL_MASK) | (srcCond & LEVEL_MASK)) & srcEnable;
   assign link.pending = req;
   assign link.flags = flags;
   assign link.pendAny = |req;

   // Lowest index is the lowest vector and wins
   always_comb begin
      link.pendIdx = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (req[i]) begin
            link.pendIdx = i[$clog2(N)-1:0];
         end
      end
   end
endmodule
`default_nettype wire

// File: cig_unit_chk.sv
/*
 * Port checker of the interrupt and guard unit.
 * Assumes it is bound to cig_unit and that one clock drives everything.
 */
`timescale 1ns/1ns
`default_nettype none
module cig_unit_chk (
   input wire logic clock, srst, busIoSpace, busRead, instrDone, instrSei, instrDis,
   input wire logic stackWe, stackRd, coreHold, vectorValid, returnValid, unlockIo, unlockProg,
   input wire logic [7:0] busAddr, busRdata, flagsOut,
   input wire logic [15:0] stackPtr, stackAddr
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);
   ////////////////////////////////////////////////////////////////////////////
   // Entry: enable dropped, two pushes downwards, vector three cycles on
   property p_entry_gie;
      $rose(stackWe) |-> !flagsOut[cig_pkg::GIE_BIT];
   endproperty
   a_entry_gie: assert property (p_entry_gie) else $error("entry left global enable set");
   property p_entry_len;
      $rose(stackWe) |-> ##1 (stackWe && stackAddr == $past(stackAddr) - 16'h0001)
         ##2 (vectorValid && !stackWe);
   endproperty
   a_entry_len: assert property (p_entry_len) else $error("entry push or length wrong");
   property p_entry_guard;
      $rose(stackWe) |-> !$past(unlockIo, 2) && !$past(unlockProg, 2);
   endproperty
   a_entry_guard: assert property (p_entry_guard) else $error("entry taken in unlock window");
   ////////////////////////////////////////////////////////////////////////////
   // Return: two pops upwards, then pointer plus two and enable set
   property p_return;
      $rose(stackRd) |-> ##1 (stackRd && stackAddr == $past(stackAddr) + 16'h0001)
         ##2 (returnValid && flagsOut[cig_pkg::GIE_BIT] && stackPtr == $past(stackPtr, 3) + 16'h0002);
   endproperty
   a_return: assert property (p_return) else $error("return sequence wrong");
   ////////////////////////////////////////////////////////////////////////////
   // Enable and disable instructions
   property p_disable_now;
      instrDone && instrDis |=> (!coreHold && !flagsOut[cig_pkg::GIE_BIT]) [*2];
   endproperty
   a_disable_now: assert property (p_disable_now) else $error("request taken at disable");
   property p_enable_late;
      instrDone && instrSei |=> (!coreHold && flagsOut[cig_pkg::GIE_BIT]) [*2];
   endproperty
   a_enable_late: assert property (p_enable_late) else $error("request taken at enable");
   ////////////////////////////////////////////////////////////////////////////
   // Register contents
   property p_guard_read;
      busRead && !busIoSpace && busAddr == cig_pkg::ADDR_GUARD |=>
         busRdata == {6'h00, $past(unlockProg), $past(unlockIo)};
   endproperty
   a_guard_read: assert property (p_guard_read) else $error("guard read value wrong");
   property p_sign;
      flagsOut[cig_pkg::SIGN_BIT] == (flagsOut[cig_pkg::NEG_BIT] ^ flagsOut[cig_pkg::OVF_BIT]);
   endproperty
   a_sign: assert property (p_sign) else $error("sign flag not n xor v");
   property p_reset_val;
      $fell(srst) |-> stackPtr == cig_pkg::LAST_SRAM_ADDRESS && flagsOut == cig_pkg::FLAGS_RESET;
   endproperty
   a_reset_val: assert property (p_reset_val) else $error("reset values wrong");
endmodule
bind cig_unit cig_unit_chk chk (.clock(clock), .srst(srst), .busIoSpace(busIoSpace), .busRead(busRead),
   .instrDone(instrDone), .instrSei(instrSei), .instrDis(instrDis), .stackWe(stackWe), .stackRd(stackRd),
   .coreHold(coreHold), .vectorValid(vectorValid), .returnValid(returnValid), .unlockIo(unlockIo),
   .unlockProg(unlockProg), .busAddr(busAddr), .busRdata(busRdata), .flagsOut(flagsOut),
   .stackPtr(stackPtr), .stackAddr(stackAddr));
`default_nettype wire

// File: cig_stack_model.sv
/*
 * Stack memory standing behind the unit's stack strobes.
 * Assumes registered strobes; read data follows one cycle after stackRd.
 */
`timescale 1ns/1ns
`default_nettype none
module cig_stack_model (
   input wire logic clock,
   input wire logic stackWe,
   input wire logic stackRd,
   input wire logic [15:0] stackAddr,
   input wire logic [7:0] stackWdata,
   output logic [7:0] stackRdData
);
   logic [7:0] mem [0:255];
   initial stackRdData = 8'h00;
   // Byte store; read data valid one cycle, toggling otherwise
   always @(posedge clock) begin
      if (stackWe) begin
         mem[stackAddr[7:0]] <= stackWdata;
      end
      stackRdData <= stackRd ? mem[stackAddr[7:0]] : ~stackRdData;
   end
endmodule
`default_nettype wire

// File: tb.sv
/*
 * Self-checking bench of the interrupt and guard unit.
 * Assumes the package, the unit, its checker and the stack model come first.
 */
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic clock, srst, busIoSpace, busWrite, busRead, instrDone, instrSei, instrDis, instrExit;
   logic sleeping, aluWe, stackWe, stackRd, coreHold, vectorValid, returnValid, unlockIo, unlockProg;
   logic [7:0] busAddr, busWdata, busRdata, aluFlags, srcCond, srcEnable, swClear;
   logic [7:0] stackRdData, stackWdata, flagsOut, rd, m, rest;
   logic [8:0] pcIn, returnPc;
   logic [15:0] stackPtr, stackAddr, n0;
   logic [15:0] nVec = 16'h0000, vLen = 16'h0000, hLen = 16'h0000;
   logic [2:0] vectorIdx, vIdx;
   int mismatches = 0, n_checks = 0;
   cig_unit #(.N(8), .LEVEL_MASK(8'h40), .PC_W(9)) uut (.*);
   cig_stack_model stk (.clock(clock), .stackWe(stackWe), .stackRd(stackRd), .stackAddr(stackAddr),
      .stackWdata(stackWdata), .stackRdData(stackRdData));
   ////////////////////////////////////////////////////////////////////////////
   // Clock at 50 MHz
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   // Entry count, source and hold length, sampled where settled
   always @(negedge clock) begin
      if (vectorValid === 1'b1) begin
         nVec <= nVec + 16'h0001;
         vIdx <= vectorIdx;
         vLen <= hLen;
      end
      hLen <= (coreHold === 1'b1) ? hLen + 16'h0001 : 16'h0000;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Compare and bus helpers
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   function automatic logic [2:0] low(input logic [7:0] v);
      logic [2:0] r;
      r = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (v[i]) begin
            r = 3'(i);
         end
      end
      return r;
   endfunction
   function automatic logic [7:0] expFlags(input logic g, input logic [7:0] f);
      return {g, f[6:5], f[2] ^ f[3], f[3:0]};
   endfunction
   task automatic wr(input logic [7:0] a, input logic io, input logic [7:0] d);
      {busAddr, busIoSpace, busWdata, busWrite} = {a, io, d, 1'b1};
      @(negedge clock);
      busWrite = 1'b0;
      @(negedge clock);
   endtask
   task automatic rdr(input logic [7:0] a, input logic io);
      {busAddr, busIoSpace, busRead} = {a, io, 1'b1};
      @(negedge clock);
      busRead = 1'b0;
      rd = busRdata;
      @(negedge clock);
   endtask
   task automatic ev(input logic [7:0] v);
      srcCond = v;
      @(negedge clock);
      srcCond = 8'h00;
   endtask
   task automatic clr();
      swClear = 8'hFF;
      @(negedge clock);
      swClear = 8'h00;
   endtask
   task automatic idle();
      for (int i = 0; i < 30 && coreHold === 1'b1; i++) begin
         @(negedge clock);
      end
      @(negedge clock); // Let the entry monitor record
   endtask
   // One instruction end: q is enable, disable, return
   task automatic ins(input logic [2:0] q);
      {instrSei, instrDis, instrExit, instrDone} = {q, 1'b1};
      @(negedge clock);
      {instrSei, instrDis, instrExit, instrDone} = 4'h0;
      @(negedge clock);
      idle();
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Watchdog against a hung run
   initial begin
      #400000;
      $display("ERROR %0t: watchdog expired", $time);
      mismatches++;
      complete_run();
   end
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      void'($urandom(32'hF3137376));
      {srst, busIoSpace, busWrite, busRead, instrDone, instrSei, instrDis, instrExit} = 8'h80;
      {sleeping, aluWe, pcIn} = 11'h000;
      {busAddr, busWdata, aluFlags, srcCond, srcEnable, swClear} = 48'h0;
      repeat (5) @(negedge clock);
      srst = 1'b0;
      rdr(cig_pkg::ADDR_GUARD, 1'b0);
      chk(rd, cig_pkg::GUARD_RESET);
      rdr(cig_pkg::ADDR_SP_LOW, 1'b0);
      chk(rd, cig_pkg::LAST_SRAM_ADDRESS[7:0]);
      wr(cig_pkg::ADDR_SP_HIGH, 1'b0, 8'hA5);
      chk(stackPtr, {8'hA5, cig_pkg::LAST_SRAM_ADDRESS[7:0]});
      wr(cig_pkg::ADDR_SP_HIGH, 1'b0, 8'h00);
      rdr(8'h7A, 1'b0);
      chk(rd, 8'h00);
      wr(cig_pkg::ADDR_FLAGS - cig_pkg::IO_OFFSET, 1'b1, 8'h04);
      rdr(cig_pkg::ADDR_FLAGS, 1'b0);
      chk(rd, 8'h14);
      for (int k = 0; k < 6; k++) begin
         {aluFlags, aluWe} = {8'($urandom), 1'b1};
         @(negedge clock);
         chk(flagsOut, expFlags(1'b0, aluFlags));
      end
      aluWe = 1'b0;
      $display("test registers done");
      ins(3'h4);
      ev(8'h08);
      ins(3'h0);
      chk(nVec, 16'h0000);
      ins(3'h2);
      srcEnable = 8'h08;
      ins(3'h4);
      chk(nVec, 16'h0000);
      pcIn = 9'($urandom);
      ins(3'h0);
      chk(vIdx, 3'h3);
      chk(vLen, 16'(cig_pkg::ENTRY_CYCLES));
      chk(flagsOut[7], 1'b0);
      chk(stackPtr, 16'h005D);
      chk({stk.mem[8'h5E], stk.mem[8'h5F]}, {7'h00, pcIn});
      ins(3'h1);
      chk(returnPc, pcIn);
      chk(stackPtr, 16'h005F);
      chk(flagsOut[7], 1'b1);
      chk(flagsOut, expFlags(1'b1, aluFlags));
      $display("test entry and return done");
      srcEnable = 8'hBF;
      for (int k = 0; k < 6; k++) begin
         m = (k == 0) ? 8'h22 : ((8'($urandom) & 8'hBF) | 8'h80);
         rest = m & ~(8'h01 << low(m));
         ins(3'h2);
         clr();
         ev(m);
         ins(3'h4);
         n0 = nVec;
         ins(3'h0);
         chk(vIdx, low(m));
         ins(3'h1);
         chk(nVec, n0 + 16'h0001);
         ins(3'h0);
         chk(nVec, (rest != 8'h00) ? n0 + 16'h0002 : n0 + 16'h0001);
         if (rest != 8'h00) begin
            chk(vIdx, low(rest));
            ins(3'h1);
         end
      end
      $display("test priority done");
      clr();
      srcEnable = 8'h00;
      ev(8'h40);
      srcEnable = 8'h40;
      n0 = nVec;
      ins(3'h0);
      chk(nVec, n0);
      srcCond = 8'h40;
      ins(3'h0);
      srcCond = 8'h00;
      chk(vIdx, 3'h6);
      ins(3'h1);
      ev(8'h05);
      swClear = 8'h04;
      @(negedge clock);
      swClear = 8'h00;
      srcEnable = 8'h05;
      ins(3'h0);
      chk(vIdx, 3'h0);
      ins(3'h1);
      n0 = nVec;
      ins(3'h0);
      chk(nVec, n0);
      srcEnable = 8'h08;
      ev(8'h08);
      ins(3'h2);
      chk(nVec, n0);
      chk(flagsOut[7], 1'b0);
      $display("test request kinds done");
      ins(3'h4);
      wr(cig_pkg::ADDR_GUARD, 1'b0, cig_pkg::SIG_PROT_UNLOCK);
      rdr(cig_pkg::ADDR_GUARD, 1'b0);
      chk(rd, 8'h01);
      repeat (3) ins(3'h0);
      chk(unlockIo, 1'b1);
      ins(3'h0);
      chk(nVec, n0);
      chk(unlockIo, 1'b0);
      ins(3'h0);
      chk(vIdx, 3'h3);
      ins(3'h1);
      wr(cig_pkg::ADDR_GUARD, 1'b0, cig_pkg::SIG_SELF_PROG);
      rdr(cig_pkg::ADDR_GUARD, 1'b0);
      chk(rd, 8'h02);
      repeat (3) ins(3'h0);
      chk(unlockProg, 1'b1);
      ins(3'h0);
      chk(unlockProg, 1'b0);
      wr(cig_pkg::ADDR_GUARD, 1'b0, 8'h55);
      rdr(cig_pkg::ADDR_GUARD, 1'b0);
      chk(rd, 8'h00);
      $display("test guard done");
      sleeping = 1'b1;
      ev(8'h08);
      for (int i = 0; i < 12 && coreHold !== 1'b1; i++) begin
         @(negedge clock);
      end
      sleeping = 1'b0;
      idle();
      chk(vLen, 16'(cig_pkg::ENTRY_CYCLES) + 16'(cig_pkg::WAKE_CYCLES));
      ins(3'h1);
      $display("test wake done");
      complete_run();
   end
endmodule
`default_nettype wire
